// file: flash_seq_pkg.sv
`default_nettype none
package flash_seq_pkg;

   // link framing and array geometry
   localparam int ADDR_W     = 24;
   localparam int PAGE_W     = 8;
   localparam int PAGE_BYTES = 256;
   localparam int EDGE_W     = 6;
   localparam int WALK_W     = 16;

   // opcodes, all shifted in on line 0
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_READ_STATUS1  = 8'h05;
   localparam logic [7:0] OP_READ_STATUS2  = 8'h35;
   localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
   localparam logic [7:0] OP_QUAD_PROGRAM  = 8'h33;
   localparam logic [7:0] OP_ERASE_SMALL   = 8'h20;
   localparam logic [7:0] OP_ERASE_HALF    = 8'h52;
   localparam logic [7:0] OP_ERASE_FULL    = 8'hd8;

   // edge counts within a frame (edge counter saturates at the cap)
   localparam logic [EDGE_W-1:0] EDGE_CAP         = 6'h3f;
   localparam logic [EDGE_W-1:0] OPCODE_EDGES     = 6'h08;
   localparam logic [EDGE_W-1:0] SPI_ADDR_EDGES   = 6'h20;
   localparam logic [EDGE_W-1:0] QUAD_ADDR_EDGES  = 6'h0e;
   localparam logic [EDGE_W-1:0] SPI_BYTE1_LAST   = 6'h27;
   localparam logic [EDGE_W-1:0] QUAD_BYTE1_LAST  = 6'h0f;
   localparam logic [EDGE_W-1:0] SPI_DATA_MIN     = 6'h28;
   localparam logic [EDGE_W-1:0] QUAD_DATA_MIN    = 6'h10;
   localparam logic [2:0]        SPI_BYTE_LAST_PH = 3'h7;

   // erase block sizes as address bit counts
   localparam int SMALL_BLOCK_W = 12;
   localparam int HALF_BLOCK_W  = 15;
   localparam int FULL_BLOCK_W  = 16;

   // status bit positions and fixed values
   localparam int         BUSY_BIT    = 0;
   localparam int         LATCH_BIT   = 1;
   localparam int         QUAD_EN_BIT = 1;
   localparam int         SO_LINE     = 1;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // self-timed durations in microseconds and core cycles
   localparam int REF_CLK_MHZ                = 32'hfa;
   localparam int PAGE_PROGRAM_TIME_US       = 32'h4;
   localparam int SMALL_BLOCK_ERASE_TIME_US  = 32'h14;
   localparam int HALF_BLOCK_ERASE_TIME_US   = 32'h28;
   localparam int FULL_BLOCK_ERASE_TIME_US   = 32'h3c;
   localparam int PAGE_PROGRAM_CYCLES        = PAGE_PROGRAM_TIME_US * REF_CLK_MHZ;
   localparam int SMALL_BLOCK_ERASE_CYCLES   = SMALL_BLOCK_ERASE_TIME_US * REF_CLK_MHZ;
   localparam int HALF_BLOCK_ERASE_CYCLES    = HALF_BLOCK_ERASE_TIME_US * REF_CLK_MHZ;
   localparam int FULL_BLOCK_ERASE_CYCLES    = FULL_BLOCK_ERASE_TIME_US * REF_CLK_MHZ;

   // summary of a finished frame, stable while chip select is high
   typedef struct packed {
      logic [7:0]        opcode;
      logic [ADDR_W-1:0] addr;
      logic [EDGE_W-1:0] edges;
      logic [2:0]        phase;
      logic              buffered;
   } frame_t;

   typedef enum {CMD_NONE, CMD_WR_ENABLE, CMD_WRDI, CMD_PROG, CMD_ERASE_SMALL,
                 CMD_ERASE_HALF, CMD_ERASE_FULL} cmd_t;

   typedef enum {ST_IDLE, ST_PROG, ST_ERASE} seq_state_t;

endpackage : flash_seq_pkg
`default_nettype wire

// file: flash_program_erase.sv
`timescale 1ns/1ns
`default_nettype none
module flash_program_erase
   import flash_seq_pkg::*;
#(
   parameter int PP_CYCLES   = PAGE_PROGRAM_CYCLES,
   parameter int SE_CYCLES   = SMALL_BLOCK_ERASE_CYCLES,
   parameter int BE32_CYCLES = HALF_BLOCK_ERASE_CYCLES,
   parameter int BE64_CYCLES = FULL_BLOCK_ERASE_CYCLES,
   parameter int TIMER_W     = 24
) (
   // core clock, reset and enable
   input  wire logic              REF_CLK_I,
   input  wire logic              RST_I,
   input  wire logic              CE_I,
   // serial link
   input  wire logic              SPI_CLK_I,
   input  wire logic              CS_N_I,
   input  wire logic [3:0]        QUAD_IO_I,
   output logic      [3:0]        QUAD_IO_O,
   output logic      [3:0]        QUAD_IO_OE_O,
   // configuration and status
   input  wire logic              QUAD_ENABLE_I,
   output logic                   BUSY_O,
   output logic                   WRITE_ENABLE_LATCH_O,
   // memory array port
   output logic      [ADDR_W-1:0] ARRAY_RADDR_O,
   input  wire logic [7:0]        ARRAY_RDATA_I,
   output logic      [ADDR_W-1:0] ARRAY_WADDR_O,
   output logic      [7:0]        ARRAY_WDATA_O,
   output logic                   ARRAY_WE_O
);

   // opcodes that fill the page buffer
   function automatic logic is_prog(input logic [7:0] op);
      return (op == OP_PAGE_PROGRAM) || (op == OP_QUAD_PROGRAM);
   endfunction : is_prog

   // opcodes that stream a status byte out
   function automatic logic is_status(input logic [7:0] op);
      return (op == OP_READ_STATUS1) || (op == OP_READ_STATUS2);
   endfunction : is_status

   // address mask that keeps only the bits above the block size
   function automatic logic [ADDR_W-1:0] block_mask(input int size_w);
      return ~((ADDR_W'(1) << size_w) - ADDR_W'(1));
   endfunction : block_mask

   // judge a finished frame by opcode, edge count and byte alignment
   function automatic cmd_t decode_frame(input frame_t f, input logic quad_en);
      cmd_t c;
      c = CMD_NONE;
      case (f.opcode)
         OP_WRITE_ENABLE:  if (f.edges == OPCODE_EDGES) c = CMD_WR_ENABLE;
         OP_WRITE_DISABLE: if (f.edges == OPCODE_EDGES) c = CMD_WRDI;
         OP_PAGE_PROGRAM:  if (f.buffered && f.edges >= SPI_DATA_MIN && f.phase == 3'h0)
                              c = CMD_PROG;
         OP_QUAD_PROGRAM:  if (quad_en && f.buffered && f.edges >= QUAD_DATA_MIN && !f.phase[0])
                              c = CMD_PROG;
         OP_ERASE_SMALL:   if (f.edges == SPI_ADDR_EDGES) c = CMD_ERASE_SMALL;
         OP_ERASE_HALF:    if (f.edges == SPI_ADDR_EDGES) c = CMD_ERASE_HALF;
         OP_ERASE_FULL:    if (f.edges == SPI_ADDR_EDGES) c = CMD_ERASE_FULL;
         default:          c = CMD_NONE;
      endcase
      return c;
   endfunction : decode_frame

   // ---------------- link domain ----------------
   logic                  fresh;
   logic [EDGE_W-1:0]     edges;
   logic [2:0]            phase;
   logic [7:0]            op_sh;
   logic [ADDR_W-1:0]     addr_sh;
   logic [7:0]            data_sh;
   logic                  buffered;
   logic [PAGE_W-1:0]     byte_idx;
   logic [7:0]            page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] page_mask;
   logic                  busy_meta;
   logic                  busy_link;
   logic                  latch_meta;
   logic                  latch_link;
   logic                  quad_en_meta;
   logic                  quad_en_link;
   logic                  quad_en_sync;
   logic                  so_bit;
   logic                  so_oe;
   logic [EDGE_W-1:0]     cur;
   logic [2:0]            cur_phase;
   logic [7:0]            next_op;
   logic [7:0]            next_byte;
   logic                  byte_done;
   logic                  quad_op;
   logic [PAGE_W-1:0]     byte_pos;
   logic [7:0]            status_byte;

   // first edge of a frame restarts the counters from zero
   assign cur       = fresh ? '0 : edges;
   assign cur_phase = fresh ? 3'h0 : phase;
   assign next_op   = {op_sh[6:0], QUAD_IO_I[0]};
   assign quad_op   = (op_sh == OP_QUAD_PROGRAM);
   assign byte_pos  = addr_sh[PAGE_W-1:0] + byte_idx;

   // byte assembly differs only in line width
   always_comb begin
      if (quad_op) begin
         next_byte = {data_sh[3:0], QUAD_IO_I};
         byte_done = buffered && cur >= QUAD_BYTE1_LAST && cur_phase[0];
      end else begin
         next_byte = {data_sh[6:0], QUAD_IO_I[0]};
         byte_done = buffered && cur >= SPI_BYTE1_LAST && cur_phase == SPI_BYTE_LAST_PH;
      end
   end

   // chip select high marks the next edge as a frame start
   always_ff @(posedge SPI_CLK_I or posedge CS_N_I) begin
      if (CS_N_I) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   // edge count saturates; the phase keeps bit position within a byte
   always_ff @(posedge SPI_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         edges <= '0;
         phase <= 3'h0;
      end else begin
         edges <= (cur == EDGE_CAP) ? cur : cur + 6'h01;
         phase <= cur_phase + 3'h1;
      end
   end

   // opcode, then address msb first on one or four lines
   always_ff @(posedge SPI_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         op_sh   <= 8'h00;
         addr_sh <= '0;
         data_sh <= 8'h00;
      end else begin
         if (cur < OPCODE_EDGES) begin
            op_sh <= next_op;
         end
         if (quad_op && cur >= OPCODE_EDGES && cur < QUAD_ADDR_EDGES) begin
            addr_sh <= {addr_sh[ADDR_W-5:0], QUAD_IO_I};
         end else if (!quad_op && cur >= OPCODE_EDGES && cur < SPI_ADDR_EDGES) begin
            addr_sh <= {addr_sh[ADDR_W-2:0], QUAD_IO_I[0]};
         end
         data_sh <= quad_op ? {data_sh[3:0], QUAD_IO_I} : {data_sh[6:0], QUAD_IO_I[0]};
      end
   end

   // buffer is claimed by a program opcode only while idle, so it stays still while busy
   always_ff @(posedge SPI_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         buffered  <= 1'b0;
         byte_idx  <= '0;
         page_mask <= '0;
      end else if (cur == OPCODE_EDGES - 6'h01) begin
         buffered <= is_prog(next_op) && !busy_link;
         byte_idx <= '0;
         if (is_prog(next_op) && !busy_link) begin
            page_mask <= '0;
         end
      end else if (byte_done) begin
         byte_idx            <= byte_idx + 8'h01;
         page_mask[byte_pos] <= 1'b1;
      end
   end

   // page buffer storage, later bytes overwrite earlier ones
   always_ff @(posedge SPI_CLK_I) begin
      if (byte_done) begin
         page_buf[byte_pos] <= next_byte;
      end
   end

   // core levels brought onto the link clock
   always_ff @(posedge SPI_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         busy_meta <= 1'b0;
         busy_link <= 1'b0;
         latch_meta   <= 1'b0;
         latch_link   <= 1'b0;
         quad_en_meta <= 1'b0;
         quad_en_link <= 1'b0;
      end else begin
         busy_meta    <= BUSY_O;
         busy_link    <= busy_meta;
         latch_meta   <= WRITE_ENABLE_LATCH_O;
         latch_link   <= latch_meta;
         quad_en_meta <= quad_en_sync;
         quad_en_link <= quad_en_meta;
      end
   end

   // status byte for the read status opcodes
   always_comb begin
      status_byte = 8'h00;
      if (op_sh == OP_READ_STATUS1) begin
         status_byte[BUSY_BIT] = busy_link;
         status_byte[LATCH_BIT] = latch_link;
      end else begin
         status_byte[QUAD_EN_BIT] = quad_en_link;
      end
   end

   // status shifts out msb first on falling edges, repeating until chip select rises
   always_ff @(negedge SPI_CLK_I or posedge CS_N_I or posedge RST_I) begin
      if (CS_N_I || RST_I) begin
         so_oe  <= 1'b0;
         so_bit <= 1'b0;
      end else if (!fresh && edges >= OPCODE_EDGES && is_status(op_sh)) begin
         so_oe  <= 1'b1;
         so_bit <= status_byte[~phase];
      end
   end

   // only the serial output line is ever driven
   always_comb begin
      QUAD_IO_O             = 4'h0;
      QUAD_IO_OE_O          = 4'h0;
      QUAD_IO_O[SO_LINE]    = so_bit;
      QUAD_IO_OE_O[SO_LINE] = so_oe;
   end

   // ---------------- core domain ----------------
   logic               cs_meta;
   logic               cs_sync;
   logic               cs_prev;
   logic               quad_en_meta_core;
   logic               frame_end;
   frame_t             frame;
   cmd_t               cmd;
   logic               accept;
   seq_state_t         state;
   logic [WALK_W-1:0]  walk_idx;
   logic [WALK_W-1:0]  walk_last;
   logic [ADDR_W-1:0]  op_base;
   logic [TIMER_W-1:0] timer;
   logic [TIMER_W-1:0] limit;
   logic               rd_act;
   logic               busy;
   logic               latch;

   // chip select and quad enable pass two flops before use
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cs_meta      <= 1'b1;
         cs_sync      <= 1'b1;
         cs_prev      <= 1'b1;
         quad_en_meta_core <= 1'b0;
         quad_en_sync      <= 1'b0;
      end else if (CE_I) begin
         cs_meta           <= CS_N_I;
         cs_sync           <= cs_meta;
         cs_prev           <= cs_sync;
         quad_en_meta_core <= QUAD_ENABLE_I;
         quad_en_sync      <= quad_en_meta_core;
      end
   end

   // link registers are quiet once chip select is high, so the summary is safe to sample
   assign frame_end = cs_sync && !cs_prev;
   assign frame     = '{opcode: op_sh, addr: addr_sh, edges: edges, phase: phase, buffered: buffered};
   assign cmd       = decode_frame(frame, quad_en_sync);
   assign accept    = frame_end && !busy && latch &&
                      (cmd == CMD_PROG || cmd == CMD_ERASE_SMALL ||
                       cmd == CMD_ERASE_HALF || cmd == CMD_ERASE_FULL);

   // write enable latch
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         latch <= 1'b0;
      end else if (CE_I) begin
         if (accept) begin
            latch <= 1'b0;
         end else if (frame_end && !busy && cmd == CMD_WR_ENABLE) begin
            latch <= 1'b1;
         end else if (frame_end && !busy && cmd == CMD_WRDI) begin
            latch <= 1'b0;
         end
      end
   end

   // sequencer: walk the page or block while the timer runs; busy covers both
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state         <= ST_IDLE;
         busy          <= 1'b0;
         walk_idx      <= '0;
         walk_last     <= '0;
         op_base       <= '0;
         timer         <= '0;
         limit         <= '0;
         rd_act        <= 1'b0;
         ARRAY_RADDR_O <= '0;
      end else if (CE_I) begin
         unique case (state)
            ST_IDLE: begin
               if (accept) begin
                  busy     <= 1'b1;
                  timer    <= '0;
                  walk_idx <= '0;
                  rd_act   <= 1'b1;
                  unique case (cmd)
                     CMD_PROG: begin
                        state         <= ST_PROG;
                        op_base       <= frame.addr & block_mask(PAGE_W);
                        ARRAY_RADDR_O <= frame.addr & block_mask(PAGE_W);
                        walk_last     <= WALK_W'(PAGE_BYTES - 1);
                        limit         <= TIMER_W'(PP_CYCLES - 1);
                     end
                     CMD_ERASE_SMALL: begin
                        state         <= ST_ERASE;
                        op_base       <= frame.addr & block_mask(SMALL_BLOCK_W);
                        ARRAY_RADDR_O <= frame.addr & block_mask(SMALL_BLOCK_W);
                        walk_last     <= WALK_W'(~block_mask(SMALL_BLOCK_W));
                        limit         <= TIMER_W'(SE_CYCLES - 1);
                     end
                     CMD_ERASE_HALF: begin
                        state         <= ST_ERASE;
                        op_base       <= frame.addr & block_mask(HALF_BLOCK_W);
                        ARRAY_RADDR_O <= frame.addr & block_mask(HALF_BLOCK_W);
                        walk_last     <= WALK_W'(~block_mask(HALF_BLOCK_W));
                        limit         <= TIMER_W'(BE32_CYCLES - 1);
                     end
                     default: begin
                        state         <= ST_ERASE;
                        op_base       <= frame.addr & block_mask(FULL_BLOCK_W);
                        ARRAY_RADDR_O <= frame.addr & block_mask(FULL_BLOCK_W);
                        walk_last     <= WALK_W'(~block_mask(FULL_BLOCK_W));
                        limit         <= TIMER_W'(BE64_CYCLES - 1);
                     end
                  endcase
               end
            end
            ST_PROG, ST_ERASE: begin
               if (timer != limit) begin
                  timer <= timer + TIMER_W'(1);
               end
               if (rd_act) begin
                  if (walk_idx == walk_last) begin
                     rd_act <= 1'b0;
                  end else begin
                     walk_idx      <= walk_idx + WALK_W'(1);
                     ARRAY_RADDR_O <= op_base | ADDR_W'(walk_idx + WALK_W'(1));
                  end
               end
               // the longer of walk and timer decides the end
               if (!rd_act && !ARRAY_WE_O && timer == limit) begin
                  state <= ST_IDLE;
                  busy  <= 1'b0;
               end
            end
         endcase
      end
   end

   // write pipeline: one cycle after each read address, merge and write back
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ARRAY_WE_O    <= 1'b0;
         ARRAY_WADDR_O <= '0;
         ARRAY_WDATA_O <= 8'h00;
      end else if (CE_I) begin
         ARRAY_WADDR_O <= ARRAY_RADDR_O;
         if (state == ST_ERASE) begin
            ARRAY_WE_O    <= rd_act;
            ARRAY_WDATA_O <= ERASED_BYTE;
         end else begin
            // bits only fall to zero, and unsent bytes are skipped
            ARRAY_WE_O    <= rd_act && page_mask[ARRAY_RADDR_O[PAGE_W-1:0]];
            ARRAY_WDATA_O <= ARRAY_RDATA_I & page_buf[ARRAY_RADDR_O[PAGE_W-1:0]];
         end
      end
   end

   assign BUSY_O               = busy;
   assign WRITE_ENABLE_LATCH_O = latch;

endmodule : flash_program_erase
`default_nettype wire

// file: flash_seq_props.sv
`timescale 1ns/1ns
`default_nettype none
module flash_seq_props
   import flash_seq_pkg::*;
(
   // watched ports
   input wire logic              REF_CLK_I,
   input wire logic              RST_I,
   input wire logic              CS_N_I,
   input wire logic              BUSY_O,
   input wire logic              WRITE_ENABLE_LATCH_O,
   input wire logic [ADDR_W-1:0] ARRAY_RADDR_O,
   input wire logic [7:0]        ARRAY_RDATA_I,
   input wire logic [ADDR_W-1:0] ARRAY_WADDR_O,
   input wire logic [7:0]        ARRAY_WDATA_O,
   input wire logic              ARRAY_WE_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   // a timed operation never ends within its first cycles
   sequence busy_run; BUSY_O[*8]; endsequence
   busy_start_a: assert property ($rose(BUSY_O) |-> CS_N_I && $past(CS_N_I))
      else $error("operation started inside a frame");
   busy_hold_a: assert property ($rose(BUSY_O) |-> busy_run)
      else $error("busy dropped too early");
   latch_clear_a: assert property ($rose(BUSY_O) |-> !WRITE_ENABLE_LATCH_O)
      else $error("latch not cleared at busy");
   latch_busy_a: assert property (BUSY_O |-> !WRITE_ENABLE_LATCH_O)
      else $error("latch set while busy");
   latch_set_a: assert property ($rose(WRITE_ENABLE_LATCH_O) |-> !BUSY_O && CS_N_I)
      else $error("latch set at a wrong moment");
   write_busy_a: assert property (ARRAY_WE_O |-> BUSY_O)
      else $error("array write while idle");
   write_addr_a: assert property (ARRAY_WE_O |-> ARRAY_WADDR_O == $past(ARRAY_RADDR_O))
      else $error("write address differs from read address");
   write_and_a: assert property (ARRAY_WE_O && ARRAY_WDATA_O != ERASED_BYTE |->
      (ARRAY_WDATA_O & ~$past(ARRAY_RDATA_I)) == 8'h00)
      else $error("program set a bit to one");
   walk_end_a: assert property ($fell(BUSY_O) |-> !ARRAY_WE_O)
      else $error("busy fell during a write");
endmodule : flash_seq_props
bind flash_program_erase flash_seq_props props (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .CS_N_I(CS_N_I),
   .BUSY_O(BUSY_O), .WRITE_ENABLE_LATCH_O(WRITE_ENABLE_LATCH_O), .ARRAY_RADDR_O(ARRAY_RADDR_O),
   .ARRAY_RDATA_I(ARRAY_RDATA_I), .ARRAY_WADDR_O(ARRAY_WADDR_O), .ARRAY_WDATA_O(ARRAY_WDATA_O),
   .ARRAY_WE_O(ARRAY_WE_O));
`default_nettype wire

// file: flash_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
   // link towards the device
   output logic       sclk,
   output logic       cs_n,
   output logic [3:0] io
);
   logic [7:0] dat [0:299];
   // idle link: clock parked low, chip select high
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io = 4'h0;
   end
   // one link clock; unused lines toggle so a stale value never looks valid
   task automatic sh(input logic [3:0] v, input bit q);
      io = q ? v : {~io[3:1], v[0]};
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
   endtask : sh
   // whole frame: opcode on line 0, then address, data and stray bits
   task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na, nd, extra, input bit q);
      int i;
      int j;
      cs_n = 1'b0;
      #7;
      for (i = 7; i >= 0; i--) sh({3'h0, op[i]}, 1'b0);
      for (i = na - 1; i >= 0; i -= q ? 4 : 1) sh(q ? a[i-:4] : {3'h0, a[i]}, q);
      for (j = 0; j < nd; j++)
         for (i = 7; i >= 0; i -= q ? 4 : 1) sh(q ? dat[j][i-:4] : {3'h0, dat[j][i]}, q);
      for (i = 0; i < extra; i++) sh(4'h5, q);
      #7 cs_n = 1'b1;
      io = ~io;
      #40;
   endtask : frame
endmodule : flash_host_model
`default_nettype wire

// file: serial_flash_program_erase_bench.sv
`timescale 1ns/1ns
`default_nettype none
module serial_flash_program_erase_bench;
   import flash_seq_pkg::*;
   logic              clk, rst, quad_en, busy, latch, we, sclk, cs_n;
   logic [7:0]        so_cap;
   logic [3:0]        hio, io_o, io_oe, io_in;
   logic [ADDR_W-1:0] raddr, waddr;
   logic [7:0]        rdata, wdata;
   logic [7:0]        mem [int];
   logic [31:0]       expq [$];
   logic [31:0]       seed;
   int                miscompares = 0;
   int                checks = 0;

   // device drive wins on the lines it enables
   assign io_in = (io_oe & io_o) | (~io_oe & hio);
   // status bits are launched on falling edges, so the host takes them on rising ones
   always @(posedge sclk) if (io_oe[1] === 1'b1) so_cap = {so_cap[6:0], io_o[1]};
   flash_host_model host (.sclk(sclk), .cs_n(cs_n), .io(hio));
   // short timed counts keep the run brief; walks still run in full
   flash_program_erase #(.PP_CYCLES(300), .SE_CYCLES(300), .BE32_CYCLES(300)) uut (
      .REF_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .SPI_CLK_I(sclk), .CS_N_I(cs_n),
      .QUAD_IO_I(io_in), .QUAD_IO_O(io_o), .QUAD_IO_OE_O(io_oe), .QUAD_ENABLE_I(quad_en),
      .BUSY_O(busy), .WRITE_ENABLE_LATCH_O(latch), .ARRAY_RADDR_O(raddr), .ARRAY_RDATA_I(rdata),
      .ARRAY_WADDR_O(waddr), .ARRAY_WDATA_O(wdata), .ARRAY_WE_O(we));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // unwritten cells hold a pattern with zeros, so and-ing shows
   function automatic logic [7:0] old(input logic [23:0] p);
      return mem.exists(int'(p)) ? mem[int'(p)] : p[7:0] ^ 8'h5a;
   endfunction : old
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   // array model: each write is matched against the oldest note
   always @(posedge clk) if (we === 1'b1) begin
      chk({waddr, wdata}, expq.size() != 0 ? expq.pop_front() : 32'hx);
      mem[int'(waddr)] = wdata;
   end
   always @(raddr) rdata = old(raddr);
   task automatic judge(input logic ok);
      @(negedge clk);
      chk(busy, ok);
      if (ok) chk(latch, 1'b0);
   endtask : judge
   task automatic await_done();
      int i;
      for (i = 0; i < 40000 && busy === 1'b1; i++) @(negedge clk);
      chk(busy, 1'b0);
      chk(expq.size(), 0);
   endtask : await_done
   task automatic write_enable();
      host.frame(OP_WRITE_ENABLE, 24'h0, 0, 0, 0, 1'b0);
      @(negedge clk);
      chk(latch, 1'b1);
   endtask : write_enable
   // one status byte read back on the serial output line
   task automatic status(input logic [7:0] op, input logic [7:0] exp);
      so_cap = 8'h00;
      host.frame(op, 24'h0, 0, 0, 8, 1'b0);
      chk(so_cap, exp);
      chk(io_oe, 4'h0);
   endtask : status
   task automatic prog(input logic [7:0] op, input logic [23:0] a, input int nd, extra, input logic ok);
      logic [7:0] nb [256];
      bit         hit [256];
      int         i;
      int         k;
      hit = '{default: 1'b0};
      for (i = 0; i < nd; i++) begin
         seed = xs(seed);
         host.dat[i] = seed[7:0];
         k = (a[7:0] + i) & 255;
         nb[k] = seed[7:0];
         hit[k] = 1'b1;
      end
      for (i = 0; i < 256; i++)
         if (ok && hit[i]) expq.push_back({a[23:8], 8'(i), old({a[23:8], 8'(i)}) & nb[i]});
      host.frame(op, a, 24, nd, extra, op == OP_QUAD_PROGRAM);
      judge(ok);
   endtask : prog
   task automatic erase(input logic [7:0] op, input logic [23:0] a, input int w, extra, input logic ok);
      int i;
      for (i = 0; ok && i < (1 << w); i++) expq.push_back({((a >> w) << w) + 24'(i), ERASED_BYTE});
      host.frame(op, a, 24, 0, extra, 1'b0);
      judge(ok);
   endtask : erase
   // hang guard, well beyond the longest erase walk
   initial begin
      #400000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      quad_en = 1'b0;
      seed = 32'h000159bc;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      prog(OP_PAGE_PROGRAM, 24'h000100, 4, 0, 0);
      write_enable();
      status(OP_READ_STATUS1, 8'h02);
      prog(OP_PAGE_PROGRAM, 24'h0012f0, 20, 0, 1);
      await_done();
      write_enable();
      prog(OP_PAGE_PROGRAM, 24'h000200, 6, 3, 0);
      prog(OP_QUAD_PROGRAM, 24'h000a10, 5, 0, 0);
      @(posedge clk) #1 quad_en = 1'b1;
      status(OP_READ_STATUS2, 8'h02);
      prog(OP_QUAD_PROGRAM, 24'h000500, 300, 0, 1);
      await_done();
      write_enable();
      erase(OP_ERASE_SMALL, 24'h003abc, 12, 0, 1);
      status(OP_READ_STATUS1, 8'h01);
      host.frame(OP_WRITE_ENABLE, 24'h0, 0, 0, 0, 1'b0);
      await_done();
      chk(latch, 1'b0);
      write_enable();
      erase(OP_ERASE_HALF, 24'h012345, 15, 8, 0);
      erase(OP_ERASE_HALF, 24'h012345, 15, 0, 1);
      await_done();
      erase(OP_ERASE_FULL, 24'h020000, 16, 0, 0);
      report_and_stop();
   end
endmodule : serial_flash_program_erase_bench
`default_nettype wire
